// File: design/pct_pkg.sv
package pct_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int LOGIC_CYCLE_US = 10_000;
	localparam int TICK_CLKS = LOGIC_CYCLE_US * (CLK_HZ / 1_000_000);
	localparam int HALF_S_US = 500_000;
	localparam int HALF_S_TICKS = HALF_S_US / LOGIC_CYCLE_US;
	localparam int TW = 17;
	localparam int CW = 16;
	localparam int NTIMER = 5;
	localparam int STD_UNIT_US = 10_000;
	localparam int STD_MIN_US = 10_000;
	localparam int STD_MAX_MS = 1_098_300;
	localparam logic [16:0] STD_MIN = 17'(STD_MIN_US / STD_UNIT_US);
	localparam logic [16:0] STD_MAX = 17'(STD_MAX_MS * 1000 / STD_UNIT_US);
	localparam int LONG_MIN_MS = 500;
	localparam int LONG_MAX_S = 54_915;
	localparam int LONG_FINE_MAX_S = 3000;
	localparam int LONG_COARSE_S = 5;
	localparam int HALF_PER_S = 1_000_000 / HALF_S_US;
	localparam logic [16:0] LONG_MIN = 17'(LONG_MIN_MS * 1000 / HALF_S_US);
	localparam logic [16:0] LONG_MAX = 17'(LONG_MAX_S * HALF_PER_S);
	localparam logic [16:0] LONG_FINE_MAX = 17'(LONG_FINE_MAX_S * HALF_PER_S);
	localparam logic [16:0] LONG_COARSE = 17'(LONG_COARSE_S * HALF_PER_S);
	localparam logic [1:0] AUTO_PULSE_CYCLES = 2'h2;
	localparam int T_MONO = 0;
	localparam int T_MONOB = 1;
	localparam int T_PMC = 2;
	localparam int T_DLY = 3;
	localparam int T_LDLY = 4;
	localparam logic [7:0] ADR_CFG = 8'h00;
	localparam logic [7:0] ADR_CNT_PRESET = 8'h04;
	localparam logic [7:0] ADR_CNT_THRESH = 8'h08;
	localparam logic [7:0] ADR_TIME_THRESH = 8'h0C;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	localparam logic [7:0] ADR_COUNT = 8'h14;
	localparam logic [7:0] ADR_TVALUE = 8'h18;
	localparam logic [7:0] ADR_DUR0 = 8'h20;
	localparam logic [7:0] ADR_DUR_LAST = 8'h30;
	localparam logic [14:0] CFG_RST = 15'h54B0;
	localparam logic [15:0] PRESET_RST = 16'h0006;
	localparam logic [15:0] CTHRESH_RST = 16'h0000;
	localparam logic [16:0] TTHRESH_RST = 17'h00000;
	localparam logic [16:0] DUR_RST = 17'h00001;

	typedef enum logic [1:0] {MODE_AUTO, MODE_MANUAL, MODE_COMBINED} cnt_mode_type;

	typedef struct packed {
		logic ldly_value_en;
		logic ldly_retrig;
		logic ldly_rise;
		logic dly_retrig;
		logic dly_rise;
		logic pmc_retrig;
		logic monob_retrig;
		logic monob_rise;
		logic mono_retrig;
		logic mono_rise;
		logic cnt_status_en;
		logic cnt_double;
		logic decrement_select;
		logic [1:0] cnt_mode;
	} cfg_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
	} wb_req_type;

	typedef struct packed {
		logic [31:0] dat;
		logic ack;
	} wb_rsp_type;

	typedef struct packed {
		logic cnt_in;
		logic clear_in;
		logic mono_in;
		logic monob_in;
		logic pmc_in;
		logic dly_in;
		logic ldly_in;
	} sig_in_type;

	typedef struct packed {
		logic cnt_q;
		logic cnt_ge;
		logic mono_q;
		logic monob_q;
		logic pmc_q;
		logic dly_q;
		logic ldly_q;
		logic time_ge;
	} sig_out_type;
endpackage

// File: design/pulse_counter_and_timers.sv
// Summary of operation
// - Counter offers automatic, manual and manual-plus-automatic modes.
// - Automatic mode pulses the output for two logic cycles at the count.
// - Manual mode latches output high at the count until clear.
// - Combined mode pulses one logic cycle; clear returns the count to zero, or to the preset when decrementing.
// - Decrement option makes each counted edge decrement the count.
// - Double-edge option counts both edges, else rising edges only.
// - Status option puts the live count on the count value output.
// - Count check is high when count value is at or above threshold.
// - Standard timers accept durations from 10 ms to 1,098.3 s.
// - Rising monostable goes high for the duration, extended while input high.
// - Falling monostable goes low for the duration, extended while input low.
// - Retrigger restarts both monostables on every input change.
// - Non-extendable monostable without retrigger never stays active beyond its duration.
// - Passing contact passes a high input, cut by duration or falling edge.
// - Retriggered passing contact ignores falls and restarts on rising edges.
// - Switch-on delay rises after the duration while input stays high.
// - Off delay rises at input rise, falls at expiry only if input low.
// - Retrigger restarts delay and long delay on every input change.
// - Long delay spans 0.5 s to 54,915 s, coarse 5 s steps above 3000 s.
// - Timer value option exports the long delay elapsed time.
// - Time check is high when timer value is at or above threshold.
`timescale 1ns/100ps
module delay_stage #(
	parameter int TW = pct_pkg::TW
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic step,
	input wire logic in_now,
	input wire logic in_prev,
	input wire logic rise_mode,
	input wire logic retrig,
	input wire logic [TW-1:0] dur,
	output logic out_q,
	output logic [TW-1:0] el_q
);
	logic run_q;
	logic chg;
	logic up;
	logic down;
	logic start;
	logic expire;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	assign chg = tick && (in_now != in_prev);
	assign up = chg && in_now;
	assign down = chg && !in_now;
	assign start = (rise_mode ? up : down) || (retrig && chg);
	assign expire = run_q && step && !start && (el_q + TW'(1) >= dur);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			el_q <= '0;
		end else if (start) begin
			run_q <= 1'b1;
			el_q <= '0;
		end else if (rise_mode && down) begin
			run_q <= 1'b0;
			el_q <= '0;
		end else if (expire) begin
			run_q <= 1'b0;
			el_q <= el_q + TW'(1);
		end else if (run_q && step) begin
			el_q <= el_q + TW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_q <= 1'b0;
		end else if (rise_mode) begin
			if (tick) begin
				out_q <= in_now && !start && (expire || out_q);
			end
		end else if (up) begin
			out_q <= 1'b1;
		end else if (expire && !in_now) begin
			out_q <= 1'b0;
		end
	end

	chk_on_drop: assert property (tick && rise_mode && !in_now |=> !out_q)
		else $error("switch-on delay output high with input low");
	chk_off_expire: assert property (
		!rise_mode && expire && !in_now |=> !out_q)
		else $error("off delay did not fall at expiry");
	chk_retrig_restart: assert property (
		retrig && chg |=> run_q && el_q == '0)
		else $error("delay not restarted on input change");
endmodule

module pulse_counter_and_timers #(
	parameter int TICK_CLKS = pct_pkg::TICK_CLKS,
	parameter int HALF_TICKS = pct_pkg::HALF_S_TICKS,
	parameter int CW = pct_pkg::CW
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire pct_pkg::wb_req_type wb_req,
	output pct_pkg::wb_rsp_type wb_rsp,
	input wire pct_pkg::sig_in_type sig_in,
	output pct_pkg::sig_out_type sig_out,
	output logic [CW-1:0] count_value,
	output logic [pct_pkg::TW-1:0] timer_value
);
	localparam int TW = pct_pkg::TW;

	pct_pkg::cfg_type cfg_q;
	pct_pkg::cnt_mode_type mode_c;
	pct_pkg::sig_in_type prev_q;
	logic [CW-1:0] preset_q;
	logic [CW-1:0] cthresh_q;
	logic [TW-1:0] tthresh_q;
	logic [TW-1:0] dur_q [pct_pkg::NTIMER];
	logic [31:0] tick_cnt_q;
	logic [15:0] half_cnt_q;
	logic tick;
	logic half_step;
	logic ack_q;
	logic [31:0] rdat_q;
	logic [31:0] rd_c;
	logic [31:0] wd;
	logic aligned;
	logic dur_sel;
	logic [2:0] dur_idx;
	logic wr;
	logic [CW-1:0] count_q;
	logic [CW-1:0] nxt_cnt;
	logic [CW-1:0] start_val;
	logic [CW-1:0] target;
	logic cnt_edge;
	logic cnt_hit;
	logic clr;
	logic cnt_out_q;
	logic [1:0] pulse_q;
	logic [CW-1:0] cval_q;
	logic [TW-1:0] tval_q;
	logic cnt_ge_q;
	logic time_ge_q;
	logic [1:0] mono_q;
	logic pmc_run_q;
	logic pmc_out_q;
	logic [TW-1:0] pmc_el_q;
	logic pmc_up;
	logic pmc_down;
	logic pmc_exp;
	logic dly_out;
	logic ldly_out;
	logic [TW-1:0] ldly_el;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	function automatic logic [TW-1:0] clamp_std(input logic [TW-1:0] v);
		logic [TW-1:0] r;
		r = v;
		if (v < pct_pkg::STD_MIN) begin
			r = pct_pkg::STD_MIN;
		end else if (v > pct_pkg::STD_MAX) begin
			r = pct_pkg::STD_MAX;
		end
		return r;
	endfunction

	function automatic logic [TW-1:0] clamp_long(input logic [TW-1:0] v);
		logic [TW-1:0] r;
		r = v;
		if (v < pct_pkg::LONG_MIN) begin
			r = pct_pkg::LONG_MIN;
		end else if (v > pct_pkg::LONG_MAX) begin
			r = pct_pkg::LONG_MAX;
		end
		if (r > pct_pkg::LONG_FINE_MAX) begin
			r = r - (r % pct_pkg::LONG_COARSE);
		end
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input pct_pkg::wb_req_type r);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (r.sel[i]) begin
				m[i*8 +: 8] = r.dat[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// ----------------------------------------------------------------
	// Logic cycle timebase.
	// ----------------------------------------------------------------
	assign tick = tick_cnt_q == 32'(TICK_CLKS - 1);
	assign half_step = tick && half_cnt_q == 16'(HALF_TICKS - 1);

	always_ff @(posedge clk) begin
		if (!rst_n || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || half_step) begin
			half_cnt_q <= '0;
		end else if (tick) begin
			half_cnt_q <= half_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_q <= '0;
		end else if (tick) begin
			prev_q <= sig_in;
		end
	end

	// ----------------------------------------------------------------
	// Register bus.
	// ----------------------------------------------------------------
	assign aligned = wb_req.adr[1:0] == 2'h0;
	assign dur_sel = aligned && wb_req.adr >= pct_pkg::ADR_DUR0 &&
		wb_req.adr <= pct_pkg::ADR_DUR_LAST;
	assign dur_idx = 3'((wb_req.adr - pct_pkg::ADR_DUR0) >> 2);
	assign wr = wb_req.cyc && wb_req.stb && wb_req.we && ack_q;
	assign wd = merge(rd_c, wb_req);

	always_comb begin
		rd_c = '0;
		if (!aligned) begin
			rd_c = '0;
		end else if (wb_req.adr == pct_pkg::ADR_CFG) begin
			rd_c = 32'(cfg_q);
		end else if (wb_req.adr == pct_pkg::ADR_CNT_PRESET) begin
			rd_c = 32'(preset_q);
		end else if (wb_req.adr == pct_pkg::ADR_CNT_THRESH) begin
			rd_c = 32'(cthresh_q);
		end else if (wb_req.adr == pct_pkg::ADR_TIME_THRESH) begin
			rd_c = 32'(tthresh_q);
		end else if (wb_req.adr == pct_pkg::ADR_STATUS) begin
			rd_c = 32'(sig_out);
		end else if (wb_req.adr == pct_pkg::ADR_COUNT) begin
			rd_c = 32'(count_q);
		end else if (wb_req.adr == pct_pkg::ADR_TVALUE) begin
			rd_c = 32'(ldly_el);
		end else if (dur_sel) begin
			rd_c = 32'(dur_q[dur_idx]);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			rdat_q <= '0;
		end else begin
			ack_q <= wb_req.cyc && wb_req.stb && !ack_q;
			rdat_q <= rd_c;
		end
	end

	assign wb_rsp.ack = ack_q;
	assign wb_rsp.dat = rdat_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_q <= pct_pkg::cfg_type'(pct_pkg::CFG_RST);
			preset_q <= pct_pkg::PRESET_RST;
			cthresh_q <= pct_pkg::CTHRESH_RST;
			tthresh_q <= pct_pkg::TTHRESH_RST;
			for (int i = 0; i < pct_pkg::NTIMER; i++) begin
				dur_q[i] <= pct_pkg::DUR_RST;
			end
		end else if (wr && aligned) begin
			if (wb_req.adr == pct_pkg::ADR_CFG) begin
				cfg_q <= pct_pkg::cfg_type'(wd[14:0]);
			end else if (wb_req.adr == pct_pkg::ADR_CNT_PRESET) begin
				preset_q <= wd[CW-1:0];
			end else if (wb_req.adr == pct_pkg::ADR_CNT_THRESH) begin
				cthresh_q <= wd[CW-1:0];
			end else if (wb_req.adr == pct_pkg::ADR_TIME_THRESH) begin
				tthresh_q <= wd[TW-1:0];
			end else if (dur_sel && dur_idx == 3'(pct_pkg::T_LDLY)) begin
				dur_q[dur_idx] <= clamp_long(wd[TW-1:0]);
			end else if (dur_sel) begin
				dur_q[dur_idx] <= clamp_std(wd[TW-1:0]);
			end
		end
	end

	// ----------------------------------------------------------------
	// Pulse counter.
	// ----------------------------------------------------------------
	assign mode_c = pct_pkg::cnt_mode_type'(cfg_q.cnt_mode);
	assign start_val = cfg_q.decrement_select ? preset_q : '0;
	assign target = cfg_q.decrement_select ? '0 : preset_q;
	assign nxt_cnt = cfg_q.decrement_select ? count_q - CW'(1) :
		count_q + CW'(1);
	assign cnt_edge = tick && ((sig_in.cnt_in && !prev_q.cnt_in) ||
		(cfg_q.cnt_double && !sig_in.cnt_in && prev_q.cnt_in));
	assign cnt_hit = cnt_edge && nxt_cnt == target;
	assign clr = tick && sig_in.clear_in && mode_c != pct_pkg::MODE_AUTO;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_q <= '0;
		end else if (clr || cnt_hit) begin
			count_q <= start_val;
		end else if (cnt_edge) begin
			count_q <= nxt_cnt;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_out_q <= 1'b0;
			pulse_q <= '0;
		end else if (tick) begin
			case (mode_c)
				pct_pkg::MODE_MANUAL: begin
					if (clr) begin
						cnt_out_q <= 1'b0;
					end else if (cnt_hit) begin
						cnt_out_q <= 1'b1;
					end
				end
				pct_pkg::MODE_COMBINED: begin
					cnt_out_q <= cnt_hit;
				end
				default: begin
					if (cnt_hit) begin
						cnt_out_q <= 1'b1;
						pulse_q <= pct_pkg::AUTO_PULSE_CYCLES - 2'h1;
					end else if (pulse_q != 2'h0) begin
						pulse_q <= pulse_q - 2'h1;
					end else begin
						cnt_out_q <= 1'b0;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Value outputs and threshold checks.
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cval_q <= '0;
			tval_q <= '0;
			cnt_ge_q <= 1'b0;
			time_ge_q <= 1'b0;
		end else if (tick) begin
			cval_q <= cfg_q.cnt_status_en ? count_q : '0;
			tval_q <= cfg_q.ldly_value_en ? ldly_el : '0;
			cnt_ge_q <= cval_q >= cthresh_q;
			time_ge_q <= tval_q >= tthresh_q;
		end
	end

	assign count_value = cval_q;
	assign timer_value = tval_q;

	// ----------------------------------------------------------------
	// Monostables, the second one non-extendable.
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_mono
		logic in_now;
		logic in_prev;
		logic rise_cfg;
		logic retrig_cfg;
		logic trig_now;
		logic trig_prev;
		logic start;
		logic expire;
		logic act;
		logic run_q;
		logic [TW-1:0] el_q;

		assign in_now = i == 0 ? sig_in.mono_in : sig_in.monob_in;
		assign in_prev = i == 0 ? prev_q.mono_in : prev_q.monob_in;
		assign rise_cfg = i == 0 ? cfg_q.mono_rise : cfg_q.monob_rise;
		assign retrig_cfg = i == 0 ? cfg_q.mono_retrig : cfg_q.monob_retrig;
		assign trig_now = in_now ^ !rise_cfg;
		assign trig_prev = in_prev ^ !rise_cfg;
		assign start = retrig_cfg ? (tick && in_now != in_prev) :
			(tick && trig_now && !trig_prev && (i == 0 || !run_q));
		assign expire = run_q && tick && !start &&
			(el_q + TW'(1) >= dur_q[i]);
		assign act = start || (run_q && !expire) ||
			(i == 0 && trig_now);

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				run_q <= 1'b0;
				el_q <= '0;
			end else if (start) begin
				run_q <= 1'b1;
				el_q <= '0;
			end else if (expire) begin
				run_q <= 1'b0;
			end else if (run_q && tick) begin
				el_q <= el_q + TW'(1);
			end
		end

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				mono_q[i] <= 1'b0;
			end else if (tick) begin
				mono_q[i] <= rise_cfg ? act : !act;
			end
		end
	end

	// ----------------------------------------------------------------
	// Passing make contact.
	// ----------------------------------------------------------------
	assign pmc_up = tick && sig_in.pmc_in && !prev_q.pmc_in;
	assign pmc_down = tick && !sig_in.pmc_in && prev_q.pmc_in &&
		!cfg_q.pmc_retrig;
	assign pmc_exp = pmc_run_q && tick && !pmc_up &&
		(pmc_el_q + TW'(1) >= dur_q[pct_pkg::T_PMC]);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pmc_run_q <= 1'b0;
			pmc_el_q <= '0;
		end else if (pmc_up) begin
			pmc_run_q <= 1'b1;
			pmc_el_q <= '0;
		end else if (pmc_down || pmc_exp) begin
			pmc_run_q <= 1'b0;
		end else if (pmc_run_q && tick) begin
			pmc_el_q <= pmc_el_q + TW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pmc_out_q <= 1'b0;
		end else if (tick) begin
			pmc_out_q <= pmc_up || (pmc_run_q && !pmc_exp && !pmc_down);
		end
	end

	// ----------------------------------------------------------------
	// Delay and long delay.
	// ----------------------------------------------------------------
	delay_stage #(.TW(TW)) u_dly (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick),
		.step(tick),
		.in_now(sig_in.dly_in),
		.in_prev(prev_q.dly_in),
		.rise_mode(cfg_q.dly_rise),
		.retrig(cfg_q.dly_retrig),
		.dur(dur_q[pct_pkg::T_DLY]),
		.out_q(dly_out),
		.el_q()
	);

	delay_stage #(.TW(TW)) u_ldly (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick),
		.step(half_step),
		.in_now(sig_in.ldly_in),
		.in_prev(prev_q.ldly_in),
		.rise_mode(cfg_q.ldly_rise),
		.retrig(cfg_q.ldly_retrig),
		.dur(dur_q[pct_pkg::T_LDLY]),
		.out_q(ldly_out),
		.el_q(ldly_el)
	);

	assign sig_out.cnt_q = cnt_out_q;
	assign sig_out.cnt_ge = cnt_ge_q;
	assign sig_out.mono_q = mono_q[0];
	assign sig_out.monob_q = mono_q[1];
	assign sig_out.pmc_q = pmc_out_q;
	assign sig_out.dly_q = dly_out;
	assign sig_out.ldly_q = ldly_out;
	assign sig_out.time_ge = time_ge_q;

	chk_cnt_cmp: assert property (
		tick |=> cnt_ge_q == ($past(cval_q) >= $past(cthresh_q)))
		else $error("count check disagrees with threshold");
	chk_time_cmp: assert property (
		tick |=> time_ge_q == ($past(tval_q) >= $past(tthresh_q)))
		else $error("time check disagrees with threshold");
	chk_manual_clear: assert property (
		tick && mode_c == pct_pkg::MODE_MANUAL && sig_in.clear_in
		|=> !cnt_out_q)
		else $error("manual clear left output high");
	chk_comb_zero: assert property (
		tick && mode_c == pct_pkg::MODE_COMBINED && sig_in.clear_in &&
		!cfg_q.decrement_select |=> count_q == '0)
		else $error("combined clear left count nonzero");
	chk_auto_pulse: assert property (
		cnt_hit && mode_c == pct_pkg::MODE_AUTO
		|=> cnt_out_q && pulse_q == 2'h1)
		else $error("automatic pulse not started");
	chk_down_step: assert property (
		cnt_edge && cfg_q.decrement_select && !cnt_hit && !clr
		|=> count_q == $past(count_q) - CW'(1))
		else $error("count did not decrement");
	chk_pmc_fall: assert property (
		tick && !cfg_q.pmc_retrig && !sig_in.pmc_in |=> !pmc_out_q)
		else $error("passing contact high with input low");
	chk_dur_range: assert property (
		dur_q[pct_pkg::T_DLY] >= pct_pkg::STD_MIN &&
		dur_q[pct_pkg::T_DLY] <= pct_pkg::STD_MAX)
		else $error("delay duration out of range");
	chk_wb_ack: assert property (ack_q |=> !ack_q)
		else $error("ack held longer than one cycle");
endmodule

// File: verification/sig_source.sv
`timescale 1ns/100ps
// ----------------------------------------
// Upstream source model
// ----------------------------------------
// Registers the wanted levels onto the block's signal inputs.
module sig_source (
	input wire logic clk,
	input wire pct_pkg::sig_in_type want,
	output pct_pkg::sig_in_type sig_in = '0
);
	// Only plain levels are driven; signal outputs, value outputs and bus reads feed the checks.
	always @(posedge clk) begin
		sig_in <= want;
	end
endmodule

// File: verification/test_pulse_counter_and_timers.sv
`timescale 1ns/100ps
// ----------------------------------------
// Testbench for the counter and timer block
// ----------------------------------------
module test_pulse_counter_and_timers;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	pct_pkg::wb_req_type req = '0;
	pct_pkg::wb_rsp_type rsp;
	pct_pkg::sig_in_type want = '0;
	pct_pkg::sig_in_type sin;
	pct_pkg::sig_out_type sout;
	pct_pkg::sig_in_type flip;
	logic [15:0] cval;
	logic [16:0] tval;
	logic [31:0] rd;
	int error_cnt = 0;
	int total_checks = 0;

	initial begin
		forever #20 clk = ~clk;
	end

	sig_source src (.clk(clk), .want(want), .sig_in(sin));

	pulse_counter_and_timers #(.TICK_CLKS(4), .HALF_TICKS(2)) dut (
		.clk(clk), .rst_n(rst_n), .wb_req(req), .wb_rsp(rsp),
		.sig_in(sin), .sig_out(sout), .count_value(cval),
		.timer_value(tval)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic we, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b1, we, a, d, 4'hF};
		do begin
			@(posedge clk);
		end while (rsp.ack !== 1'b1);
		rd = rsp.dat;
		req <= '0;
	endtask

	// Inverts one input for hi clocks and counts clocks an output is high.
	task automatic pulse(input int ib, input int hi, input int ob,
			input int exp);
		int n;
		n = 0;
		flip = pct_pkg::sig_in_type'(7'h01 << ib);
		fork
			begin
				@(posedge clk);
				want <= want ^ flip;
				repeat (hi) @(posedge clk);
				want <= want ^ flip;
			end
			repeat (64) begin
				@(posedge clk);
				if (sout[ob] === 1'b1) n++;
			end
		join
		chk(32'(n), 32'(exp));
	endtask

	task automatic test_done();
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic regs_reset();
		bus(1'b0, pct_pkg::ADR_CFG, 32'h0);
		chk(rd, 32'h0000_54B0);
		bus(1'b0, pct_pkg::ADR_CNT_PRESET, 32'h0);
		chk(rd, 32'h0000_0006);
		bus(1'b1, pct_pkg::ADR_DUR0, 32'h0001_FFFF);
		bus(1'b0, pct_pkg::ADR_DUR0, 32'h0);
		chk(rd, 32'h0001_AD06);
		bus(1'b1, 8'h40, 32'h0000_00FF);
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0000_0000);
		bus(1'b1, pct_pkg::ADR_CNT_PRESET, 32'h0000_0002);
		bus(1'b0, pct_pkg::ADR_CNT_PRESET, 32'h0);
		chk(rd, 32'h0000_0002);
	endtask

	task automatic counter_auto();
		pulse(6, 8, 7, 0);
		pulse(6, 8, 7, 8);
		bus(1'b1, pct_pkg::ADR_CFG, 32'h0000_54B8);
		pulse(6, 8, 7, 8);
	endtask

	task automatic counter_combined();
		bus(1'b1, pct_pkg::ADR_CFG, 32'h0000_54B2);
		pulse(6, 8, 7, 0);
		pulse(6, 8, 7, 4);
		pulse(6, 8, 7, 0);
		pulse(5, 8, 7, 0);
		pulse(6, 8, 7, 0);
	endtask

	task automatic counter_manual();
		bus(1'b1, pct_pkg::ADR_CFG, 32'h0000_54B1);
		pulse(5, 8, 7, 0);
		pulse(6, 8, 7, 0);
		pulse(6, 8, 4, 0);
		pulse(6, 8, 7, 64);
		pulse(5, 8, 4, 0);
		chk(32'(sout.cnt_q), 32'h0);
	endtask

	task automatic counter_compare();
		pulse(6, 8, 4, 0);
		chk(32'(cval), 32'h0000_0001);
		bus(1'b1, pct_pkg::ADR_CNT_THRESH, 32'h0000_0001);
		repeat (16) @(posedge clk);
		chk(32'(sout.cnt_ge), 32'h1);
		bus(1'b1, pct_pkg::ADR_CNT_THRESH, 32'h0000_0002);
		repeat (16) @(posedge clk);
		chk(32'(sout.cnt_ge), 32'h0);
	endtask

	task automatic counter_down();
		bus(1'b1, pct_pkg::ADR_CFG, 32'h0000_54B5);
		pulse(5, 8, 7, 0);
		chk(32'(cval), 32'h0000_0002);
		pulse(6, 8, 7, 0);
		chk(32'(cval), 32'h0000_0001);
		pulse(6, 8, 4, 0);
		chk(32'(sout.cnt_q), 32'h1);
	endtask

	task automatic timers();
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, pct_pkg::ADR_DUR0 + 8'(4 * i), 32'h0000_0003);
		end
		for (int i = 0; i < 4; i++) begin
			pulse(4 - i, 24, 5 - i, (i == 0) ? 24 : 12);
		end
		pulse(2, 8, 3, 8);
	endtask

	task automatic timers_alt();
		bus(1'b1, pct_pkg::ADR_CFG, 32'h0000_7391);
		want.mono_in <= 1'b1;
		repeat (16) @(posedge clk);
		pulse(4, 8, 5, 52);
		pulse(3, 8, 4, 20);
		pulse(2, 8, 3, 12);
		pulse(1, 8, 2, 20);
	endtask

	task automatic long_delay();
		bus(1'b1, pct_pkg::ADR_DUR_LAST, 32'h0000_1775);
		bus(1'b0, pct_pkg::ADR_DUR_LAST, 32'h0);
		chk(rd, 32'h0000_1770);
		bus(1'b1, pct_pkg::ADR_DUR_LAST, 32'h0000_0003);
		bus(1'b1, pct_pkg::ADR_TIME_THRESH, 32'h0000_0003);
		want.ldly_in <= 1'b1;
		repeat (16) @(posedge clk);
		chk(32'(sout.ldly_q), 32'h0);
		repeat (48) @(posedge clk);
		chk(32'(sout.ldly_q), 32'h1);
		chk(32'(tval), 32'h0000_0003);
		chk(32'(sout.time_ge), 32'h1);
		bus(1'b1, pct_pkg::ADR_TIME_THRESH, 32'h0000_0004);
		want.ldly_in <= 1'b0;
		repeat (64) @(posedge clk);
		chk(32'(sout.ldly_q), 32'h0);
		chk(32'(tval), 32'h0000_0003);
		chk(32'(sout.time_ge), 32'h0);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		regs_reset();
		counter_auto();
		counter_combined();
		counter_manual();
		counter_compare();
		counter_down();
		timers();
		timers_alt();
		long_delay();
		test_done();
	end

	initial begin
		repeat (6000) @(posedge clk);
		error_cnt++;
		test_done();
	end
endmodule
